// >>> design/vote_pkg.sv
// Operation
// - sixteen alarm inputs, two vote outputs
// - any-input output active on any low input
// - pair output active on adjacent lows
// - memory records events of eight inputs only
// - all-events store latches each monitored input
// - first-event store keeps only earliest input
// - three identical channels evaluate same inputs
// - channels independent, each own open-collector output
// - single group actuated by low input
// - sixteen group actuated by two lows
// - channel output low when both groups actuated
package vote_pkg;
   localparam int ALARM_COUNT = 16;
   localparam int MEM_COUNT = 8;
   localparam int CHAN_COUNT = 3;
   localparam int SYNC_STAGES = 2;
   localparam logic [15:0] ALARM_RST = 16'hffff;
   localparam logic [7:0] MEM_RST = 8'h00;
   typedef enum logic [1:0] {
      FIRST_IDLE = 2'b01,
      FIRST_HELD = 2'b10
   } first_state_t;
endpackage

// >>> design/vote_channel.sv
`timescale 1ns/1ps
// one redundant voting channel; shares no state with its siblings
module vote_channel #(
   parameter int WIDTH = 16
) (
   input wire logic mclk,
   input wire logic rstN,
   input wire logic singleN,
   input wire logic [WIDTH-1:0] groupN,
   output logic tripOe
);
   // a two-or-more group needs at least two inputs
   if (WIDTH < 2) begin : gBadWidth
      $error("vote_channel: group narrower than two inputs");
   end

   // two or more low inputs in the group
   function automatic logic twoOrMore(input logic [WIDTH-1:0] lowBits);
      logic seen;
      logic many;
      seen = 1'b0;
      many = 1'b0;
      for (int i = 0; i < WIDTH; i++) begin
         if (lowBits[i]) begin
            many = many | seen;
            seen = 1'b1;
         end
      end
      return many;
   endfunction

   // registered open-collector enable: pulls the line low when tripped
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         tripOe <= 1'b0;
      end else begin
         tripOe <= !singleN && twoOrMore(~groupN);
      end
   end

   chk_trip_cause: assert property (@(posedge mclk) disable iff (!rstN)
      tripOe |-> $past(!singleN && twoOrMore(~groupN)))
      else $error("channel tripped without both groups actuated");
   chk_single_gate: assert property (@(posedge mclk) disable iff (!rstN)
      singleN |=> !tripOe)
      else $error("channel tripped with single group idle");
endmodule

// >>> design/protection_vote_logic.sv
`timescale 1ns/1ps
// sixteen-input vote, event memory on the low eight, triple-redundant trip
module protection_vote_logic #(
   parameter int ALARMS = vote_pkg::ALARM_COUNT,
   parameter int MEMS = vote_pkg::MEM_COUNT,
   parameter int CHANS = vote_pkg::CHAN_COUNT
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [ALARMS-1:0] alarmN,
   input wire logic singleAlarmN,
   input wire logic memClear,
   output logic anyTripN_r,
   output logic pairTripN_r,
   output logic [MEMS-1:0] allEventStore_r,
   output logic [MEMS-1:0] first_event_store,
   output logic [CHANS-1:0] redundant_trip_outputs
);
   // a pair needs two inputs, and the memory must sit inside the alarm inputs
   if (ALARMS < 2 || MEMS < 1 || MEMS > ALARMS || CHANS < 1) begin : gBadParams
      $error("protection_vote_logic: unsupported parameters");
   end

   // lowest set bit; serves both the first-event pick and its check
   function automatic logic [MEMS-1:0] lowestOne(input logic [MEMS-1:0] vec);
      return vec & (~vec + MEMS'(1));
   endfunction

   logic [1:0] rstSync_r;
   logic rstN;
   logic [ALARMS-1:0] alarmMeta_r;
   logic [ALARMS-1:0] alarmSync_r;
   logic singleMeta_r;
   logic singleSync_r;
   logic clearMeta_r;
   logic clearSync_r;
   vote_pkg::first_state_t firstState_r;
   logic [MEMS-1:0] firstStore_r;
   logic [ALARMS-2:0] pairLow;
   logic [MEMS-1:0] lowMon;
   logic [MEMS-1:0] firstPick;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rstSync_r <= 2'b00;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstN = rstSync_r[1];

   // alarm synchronisers; idle high so the release of reset shows no false alarm
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         alarmMeta_r <= '1;
         alarmSync_r <= '1;
      end else begin
         alarmMeta_r <= alarmN;
         alarmSync_r <= alarmMeta_r;
      end
   end

   // single-group synchroniser; the first stage feeds only the second
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         singleMeta_r <= 1'b1;
         singleSync_r <= 1'b1;
      end else begin
         singleMeta_r <= singleAlarmN;
         singleSync_r <= singleMeta_r;
      end
   end

   // clear synchroniser; idle low so leaving reset never looks like a clear
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         clearMeta_r <= 1'b0;
         clearSync_r <= 1'b0;
      end else begin
         clearMeta_r <= memClear;
         clearSync_r <= clearMeta_r;
      end
   end

   // adjacent low pairs 1-2 .. 15-16
   genvar g;
   generate
      for (g = 0; g < ALARMS - 1; g++) begin : gPair
         assign pairLow[g] = !alarmSync_r[g] && !alarmSync_r[g+1];
      end
   endgenerate

   // any-input vote, active low, registered
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         anyTripN_r <= 1'b1;
      end else begin
         anyTripN_r <= &alarmSync_r;
      end
   end

   // pair vote; a lone faulty input stays quiet, which is why it exists
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         pairTripN_r <= 1'b1;
      end else begin
         pairTripN_r <= !(|pairLow);
      end
   end

   // only the low eight inputs are remembered
   assign lowMon = ~alarmSync_r[MEMS-1:0];
   // lowest index wins if several arrive in one cycle
   assign firstPick = lowestOne(lowMon);

   // all-events store; a new event beats a clear in the same cycle
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         allEventStore_r <= MEMS'(vote_pkg::MEM_RST);
      end else if (clearSync_r) begin
         allEventStore_r <= lowMon;
      end else begin
         allEventStore_r <= allEventStore_r | lowMon;
      end
   end

   // first-event store holds one bit until cleared
   always_ff @(posedge mclk or negedge rstN) begin
      if (!rstN) begin
         firstState_r <= vote_pkg::FIRST_IDLE;
         firstStore_r <= MEMS'(vote_pkg::MEM_RST);
      end else begin
         case (firstState_r)
            vote_pkg::FIRST_IDLE: begin
               if (|lowMon) begin
                  firstStore_r <= firstPick;
                  firstState_r <= vote_pkg::FIRST_HELD;
               end
            end
            vote_pkg::FIRST_HELD: begin
               if (clearSync_r) begin
                  firstStore_r <= |lowMon ? firstPick : MEMS'(vote_pkg::MEM_RST);
                  firstState_r <= |lowMon ? vote_pkg::FIRST_HELD : vote_pkg::FIRST_IDLE;
               end
            end
            // an illegal state drops the record rather than guess at it
            default: begin
               firstState_r <= vote_pkg::FIRST_IDLE;
               firstStore_r <= MEMS'(vote_pkg::MEM_RST);
            end
         endcase
      end
   end
   assign first_event_store = firstStore_r;

   // three independent channels on the same synchronised inputs
   generate
      for (g = 0; g < CHANS; g++) begin : gChan
         vote_channel #(.WIDTH(ALARMS)) uChan (
            .mclk(mclk),
            .rstN(rstN),
            .singleN(singleSync_r),
            .groupN(alarmSync_r),
            .tripOe(redundant_trip_outputs[g])
         );
      end
   endgenerate

   // vote output checks
   chk_any_vote: assert property (@(posedge mclk) disable iff (!rstN)
      !anyTripN_r == $past(!(&alarmSync_r)))
      else $error("any-input output wrong");
   chk_pair_vote: assert property (@(posedge mclk) disable iff (!rstN)
      !pairTripN_r |-> $past(|pairLow))
      else $error("pair output without adjacent lows");
   chk_pair_fire: assert property (@(posedge mclk) disable iff (!rstN)
      |pairLow |=> !pairTripN_r)
      else $error("adjacent lows did not raise the pair output");

   // event memory and channel agreement checks
   chk_all_hold: assert property (@(posedge mclk) disable iff (!rstN)
      !clearSync_r |=> (allEventStore_r & $past(allEventStore_r)) == $past(allEventStore_r))
      else $error("all-events bit lost without clear");
   chk_first_onehot: assert property (@(posedge mclk) disable iff (!rstN)
      $onehot0(firstStore_r))
      else $error("first-event store holds more than one bit");
   chk_first_keep: assert property (@(posedge mclk) disable iff (!rstN)
      (firstState_r == vote_pkg::FIRST_HELD && !clearSync_r) |=> $stable(firstStore_r))
      else $error("first-event store changed without clear");
   chk_chan_agree: assert property (@(posedge mclk) disable iff (!rstN)
      (&redundant_trip_outputs) || !(|redundant_trip_outputs))
      else $error("redundant channels disagree");
   chk_mem_upper: assert property (@(posedge mclk) disable iff (!rstN)
      (alarmSync_r[MEMS-1:0] == '1 && clearSync_r) |=> allEventStore_r == '0)
      else $error("store kept bits after clear with monitored inputs idle");
   chk_all_gain: assert property (@(posedge mclk) disable iff (!rstN)
      !clearSync_r |=> (allEventStore_r & ~$past(allEventStore_r) & ~$past(lowMon)) == '0)
      else $error("all-events bit set without its monitored input low");
   chk_all_set: assert property (@(posedge mclk) disable iff (!rstN)
      |lowMon |=> (allEventStore_r & $past(lowMon)) == $past(lowMon))
      else $error("monitored low input not latched");
   chk_first_capture: assert property (@(posedge mclk) disable iff (!rstN)
      (firstState_r == vote_pkg::FIRST_IDLE && |lowMon)
         |=> firstStore_r == lowestOne($past(lowMon)))
      else $error("first-event store missed the earliest input");
   chk_first_subset: assert property (@(posedge mclk) disable iff (!rstN)
      (firstStore_r & ~allEventStore_r) == '0)
      else $error("first-event bit missing from the all-events store");

   // main scenarios

   cov_any: cover property (@(posedge mclk) disable iff (!rstN) $fell(anyTripN_r));
   cov_pair: cover property (@(posedge mclk) disable iff (!rstN) $fell(pairTripN_r));
   cov_first: cover property (@(posedge mclk) disable iff (!rstN)
      firstState_r == vote_pkg::FIRST_HELD && |lowMon && !firstStore_r[0]);
   cov_trip: cover property (@(posedge mclk) disable iff (!rstN) $rose(redundant_trip_outputs[0]));
   cov_clear_set: cover property (@(posedge mclk) disable iff (!rstN) clearSync_r && |lowMon);
endmodule

// >>> bench/alarm_boards.sv
`timescale 1ns/1ps
// stands in for the boards' discrete alarm outputs; a board in alarm pulls its line low
module alarm_boards (
   input wire logic mclk,
   input wire logic [15:0] lowMask,
   input wire logic lowSingle,
   output logic [15:0] alarmN,
   output logic singleAlarmN
);
   // lines follow the masks at once; the bench moves masks off the edge, so alarms and
   // clear reach the block together and no same-time read of the masks can race
   always_comb begin
      alarmN = ~lowMask;
      singleAlarmN = ~lowSingle;
   end
endmodule

// >>> bench/tb_protection_vote_logic.sv
`timescale 1ns/1ps
// drives vote patterns through the boards model and checks outputs against queued notes
module tb_protection_vote_logic;
   typedef struct packed {
      logic anyN;
      logic pairN;
      logic [2:0] trip;
      logic [7:0] all;
      logic [7:0] first;
   } note_t;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic memClear = 1'b0;
   logic [15:0] lowMask = 16'h0000;
   logic lowSingle = 1'b0;
   logic [15:0] alarmN;
   logic singleAlarmN, anyTripN_r, pairTripN_r;
   logic [7:0] allEventStore_r, first_event_store, allExp, firstExp;
   logic [2:0] redundant_trip_outputs;
   logic [15:0] dirTab [6] = '{16'h0000, 16'h0008, 16'h0018, 16'hc000, 16'h0180, 16'h5555};
   note_t notes[$];
   note_t got, want;
   int err_total = 0, num_checks = 0, cycles = 0, seed = 32'h7e43;
   event sampleEv;
   always #25 mclk = ~mclk;
   alarm_boards boards (.mclk(mclk), .lowMask(lowMask), .lowSingle(lowSingle),
      .alarmN(alarmN), .singleAlarmN(singleAlarmN));
   protection_vote_logic dut (.mclk(mclk), .nrst(nrst), .alarmN(alarmN),
      .singleAlarmN(singleAlarmN), .memClear(memClear), .anyTripN_r(anyTripN_r),
      .pairTripN_r(pairTripN_r), .allEventStore_r(allEventStore_r),
      .first_event_store(first_event_store), .redundant_trip_outputs(redundant_trip_outputs));
   task automatic give_verdict;
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // sparse masks keep pairs and double lows rare enough to matter
   function automatic logic [15:0] sparse();
      return 16'($random(seed) & $random(seed) & $random(seed));
   endfunction
   // apply one pattern, note the expected outputs, wait past the 3-edge latency
   task automatic apply(input logic [15:0] m, input logic s, input logic c);
      logic [7:0] lo;
      note_t note;
      lo = m[7:0];
      lowMask = m;
      lowSingle = s;
      memClear = c;
      if (c) begin
         allExp = lo;
         firstExp = lo & (~lo + 8'h01);
      end else begin
         allExp = allExp | lo;
         if (firstExp == 8'h00) begin
            firstExp = lo & (~lo + 8'h01);
         end
      end
      note.anyN = (m == 16'h0000);
      note.pairN = ((m & (m >> 1)) == 16'h0000);
      note.trip = (s && $countones(m) >= 2) ? 3'b111 : 3'b000;
      note.all = allExp;
      note.first = firstExp;
      notes.push_back(note);
      repeat (5) @(posedge mclk);
      #2;
      ->sampleEv;
   endtask
   // watcher: pairs each settled result with the oldest note
   always @(sampleEv) begin
      got = {anyTripN_r, pairTripN_r, redundant_trip_outputs, allEventStore_r, first_event_store};
      want = notes.pop_front();
      num_checks++;
      if (got[20:16] !== want[20:16]) begin
         err_total++;
         $display("wrong value at %0t: votes %b expected %b", $time, got[20:16], want[20:16]);
      end
      if (got[15:0] !== want[15:0]) begin
         err_total++;
         $display("wrong value at %0t: stores %h expected %h", $time, got[15:0], want[15:0]);
      end
   end
   // a hang costs a mismatch; a full run needs about 250 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 1000) begin
         err_total++;
         give_verdict();
      end
   end
   initial begin
      allExp = 8'h00;
      firstExp = 8'h00;
      repeat (2) @(posedge mclk);
      #2;
      nrst = 1'b1;
      repeat (3) @(posedge mclk);
      #2;
      for (int i = 0; i < 6; i++) begin
         apply(dirTab[i], 1'b1, 1'b0);
      end
      for (int i = 0; i < 40; i++) begin
         if (i == 20) begin
            nrst = 1'b0;
            allExp = 8'h00;
            firstExp = 8'h00;
            apply(16'h0000, 1'b0, 1'b0);
            nrst = 1'b1;
            repeat (3) @(posedge mclk);
            #2;
         end
         apply(sparse(), 1'($random(seed)), (i % 10) == 9);
      end
      // let the watcher take the last result before the verdict
      @(posedge mclk);
      give_verdict();
   end
endmodule
